/* File: core/gpio_alt_pkg.sv */
// Behaviour
// - port three: eight latch bits, alternate functions
// - latch zero overrides the pin's alternate function
// - port three bits 7,6: external read/write strobes
// - bits 5,4: timer, capture and quadrature inputs
// - bits 3,2: the two external interrupt inputs
// - bit 1 serial transmit, bit 0 serial receive
// - port five byte-only: segments 15-10, pulse 7,6
// - port six byte-only: lcd segments 23 to 16
// - port seven byte-only: lcd segments 31 to 24
package gpio_alt_pkg;

  // printed register indices; byte address is four times the index
  localparam logic [7:0]  PORT_THREE_IDX   = 8'hb0;
  localparam logic [7:0]  PORT_FIVE_IDX    = 8'hb1;
  localparam logic [7:0]  PORT_SIX_IDX     = 8'hb2;
  localparam logic [7:0]  PORT_SEVEN_IDX   = 8'hb3;

  // extra control and status registers, byte addresses
  localparam logic [11:0] ALT_SEL_THREE_ADDR = 12'h300;
  localparam logic [11:0] ALT_SEL_FIVE_ADDR  = 12'h304;
  localparam logic [11:0] ALT_SEL_SIX_ADDR   = 12'h308;
  localparam logic [11:0] ALT_SEL_SEVEN_ADDR = 12'h30c;
  localparam logic [11:0] THREE_BIT_SET_ADDR = 12'h310;
  localparam logic [11:0] THREE_BIT_CLR_ADDR = 12'h314;
  localparam logic [11:0] LATCH_VIEW_ADDR    = 12'h318;

  // values after reset
  localparam logic [7:0]  LATCH_RESET      = 8'hff;
  localparam logic [7:0]  ALT_SEL_RESET    = 8'h00;

  // pins whose alternate function is an output the block drives
  localparam logic [7:0]  THREE_ALT_DRIVE  = 8'hc2;
  localparam logic [7:0]  FULL_ALT_DRIVE   = 8'hff;

  // port three bit positions
  localparam int RD_STROBE_BIT  = 7;
  localparam int WR_STROBE_BIT  = 6;
  localparam int CNT_ONE_BIT    = 5;
  localparam int CNT_ZERO_BIT   = 4;
  localparam int IRQ_ONE_BIT    = 3;
  localparam int IRQ_ZERO_BIT   = 2;
  localparam int TXD_BIT        = 1;
  localparam int RXD_BIT        = 0;

  // outputs of on-chip peripherals that may appear on pins
  typedef struct packed {
    logic        rd_strobe;
    logic        wr_strobe;
    logic        txd;
    logic        pulse_channel_seven;
    logic        pulse_channel_six;
    logic [31:10] lcd_segment_out;
  } alt_out_type;

  // pin levels handed to on-chip peripherals
  typedef struct packed {
    logic timer_one_count_in;
    logic capture_one_in;
    logic quadrature_in_b;
    logic timer_zero_count_in;
    logic capture_zero_in;
    logic quadrature_in_a;
    logic ext_irq_one;
    logic ext_irq_zero;
    logic rxd;
  } alt_in_type;

  // byte address of a printed register index
  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction : reg_addr

endpackage : gpio_alt_pkg

/* File: core/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
  import gpio_alt_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // raw pin levels and their synchronised copy
  input  wire logic [31:0] pin_i,
  output logic      [31:0] pin_sync_o
);

  logic [31:0] stage_one_q;
  logic [31:0] stage_two_q;

  // two flops; the first is read only by the second
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      stage_one_q <= 32'hffff_ffff;
      stage_two_q <= 32'hffff_ffff;
    end else begin
      stage_one_q <= pin_i;
      stage_two_q <= stage_one_q;
    end
  end

  assign pin_sync_o = stage_two_q;

endmodule : pin_sync

/* File: core/port_pin_mux.sv */
`timescale 1ns/1ps
module port_pin_mux
  import gpio_alt_pkg::*;
(
  // port state
  input  wire logic [7:0] latch_i,
  input  wire logic [7:0] alt_sel_i,
  // alternate output values and which pins may drive them
  input  wire logic [7:0] alt_val_i,
  input  wire logic [7:0] alt_drive_i,
  // next pin drive
  output logic      [7:0] pin_o,
  output logic      [7:0] pin_oe_o
);

  logic [7:0] alt_on_w;

  // alternate output only while the latch bit holds one
  assign alt_on_w = alt_sel_i & alt_drive_i & latch_i;

  // a zero latch pulls low hard; a one releases to the pull-up unless a selected output-type alternate drives
  assign pin_oe_o = alt_on_w | ~latch_i;
  assign pin_o    = alt_on_w & alt_val_i;

endmodule : port_pin_mux

/* File: core/multi_port_gpio_alt_functions.sv */
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module multi_port_gpio_alt_functions
  import gpio_alt_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // apb slave
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // port three pins
  input  wire logic [7:0]  port_three_pin_i,
  output logic      [7:0]  port_three_pin_o,
  output logic      [7:0]  port_three_pin_oe_o,
  // port five pins
  input  wire logic [7:0]  port_five_pin_i,
  output logic      [7:0]  port_five_pin_o,
  output logic      [7:0]  port_five_pin_oe_o,
  // port six pins
  input  wire logic [7:0]  port_six_pin_i,
  output logic      [7:0]  port_six_pin_o,
  output logic      [7:0]  port_six_pin_oe_o,
  // port seven pins
  input  wire logic [7:0]  port_seven_pin_i,
  output logic      [7:0]  port_seven_pin_o,
  output logic      [7:0]  port_seven_pin_oe_o,
  // on-chip peripherals
  input  wire alt_out_type alt_out_i,
  output alt_in_type       alt_in_o
);

  // port latches and alternate selects
  logic [7:0]  port_three_latch_q;
  logic [7:0]  port_three_latch_d;
  logic [7:0]  port_five_latch_q;
  logic [7:0]  port_five_latch_d;
  logic [7:0]  port_six_latch_q;
  logic [7:0]  port_six_latch_d;
  logic [7:0]  port_seven_latch_q;
  logic [7:0]  port_seven_latch_d;
  logic [7:0]  alt_sel_three_q;
  logic [7:0]  alt_sel_five_q;
  logic [7:0]  alt_sel_six_q;
  logic [7:0]  alt_sel_seven_q;

  // bus state
  logic        pready_q;
  logic        pready_d;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  // pin side registers
  logic [7:0]  three_pin_q;
  logic [7:0]  three_oe_q;
  logic [7:0]  five_pin_q;
  logic [7:0]  five_oe_q;
  logic [7:0]  six_pin_q;
  logic [7:0]  six_oe_q;
  logic [7:0]  seven_pin_q;
  logic [7:0]  seven_oe_q;
  alt_in_type  alt_in_q;
  alt_in_type  alt_in_d;

  // wires
  logic [31:0] pin_sync_w;
  logic [7:0]  three_sync_w;
  logic [7:0]  five_sync_w;
  logic [7:0]  six_sync_w;
  logic [7:0]  seven_sync_w;
  logic [7:0]  three_alt_w;
  logic [7:0]  five_alt_w;
  logic [7:0]  six_alt_w;
  logic [7:0]  seven_alt_w;
  logic [7:0]  three_pin_d;
  logic [7:0]  three_oe_d;
  logic [7:0]  five_pin_d;
  logic [7:0]  five_oe_d;
  logic [7:0]  six_pin_d;
  logic [7:0]  six_oe_d;
  logic [7:0]  seven_pin_d;
  logic [7:0]  seven_oe_d;
  logic        access_w;
  logic        wr_w;
  logic        lane_w;
  logic [7:0]  wbyte_w;
  logic        hit_three_w;
  logic        hit_five_w;
  logic        hit_six_w;
  logic        hit_seven_w;
  logic        hit_sel_three_w;
  logic        hit_sel_five_w;
  logic        hit_sel_six_w;
  logic        hit_sel_seven_w;
  logic        hit_set_w;
  logic        hit_clr_w;
  logic        hit_view_w;
  logic        mapped_w;
  logic [31:0] rd_data_w;

  // every pin passes two flops before any logic looks at it
  pin_sync u_pin_sync (
    .clk_sys_i  (clk_sys_i),
    .srst_i     (srst_i),
    .pin_i      ({port_seven_pin_i, port_six_pin_i,
                  port_five_pin_i, port_three_pin_i}),
    .pin_sync_o (pin_sync_w)
  );

  assign three_sync_w = pin_sync_w[7:0];
  assign five_sync_w  = pin_sync_w[15:8];
  assign six_sync_w   = pin_sync_w[23:16];
  assign seven_sync_w = pin_sync_w[31:24];

  // address decode; printed indices sit at four times their value
  assign hit_three_w     = paddr_i == reg_addr(PORT_THREE_IDX);
  assign hit_five_w      = paddr_i == reg_addr(PORT_FIVE_IDX);
  assign hit_six_w       = paddr_i == reg_addr(PORT_SIX_IDX);
  assign hit_seven_w     = paddr_i == reg_addr(PORT_SEVEN_IDX);
  assign hit_sel_three_w = paddr_i == ALT_SEL_THREE_ADDR;
  assign hit_sel_five_w  = paddr_i == ALT_SEL_FIVE_ADDR;
  assign hit_sel_six_w   = paddr_i == ALT_SEL_SIX_ADDR;
  assign hit_sel_seven_w = paddr_i == ALT_SEL_SEVEN_ADDR;
  assign hit_set_w       = paddr_i == THREE_BIT_SET_ADDR;
  assign hit_clr_w       = paddr_i == THREE_BIT_CLR_ADDR;
  assign hit_view_w      = paddr_i == LATCH_VIEW_ADDR;
  assign mapped_w = hit_three_w | hit_five_w | hit_six_w | hit_seven_w |
                    hit_sel_three_w | hit_sel_five_w | hit_sel_six_w |
                    hit_sel_seven_w | hit_set_w | hit_clr_w | hit_view_w;

  // one wait state: pready rises in the second access cycle
  assign access_w = psel_i & penable_i;
  assign pready_d = access_w & ~pready_q;
  assign wr_w     = access_w & pwrite_i & pready_q;
  assign lane_w   = wr_w & pstrb_i[0];
  assign wbyte_w  = pwdata_i[7:0];

  // port reads give pin levels, not latch contents
  assign rd_data_w =
    hit_three_w     ? {24'h00_0000, three_sync_w}    :
    hit_five_w      ? {24'h00_0000, five_sync_w}     :
    hit_six_w       ? {24'h00_0000, six_sync_w}      :
    hit_seven_w     ? {24'h00_0000, seven_sync_w}    :
    hit_sel_three_w ? {24'h00_0000, alt_sel_three_q} :
    hit_sel_five_w  ? {24'h00_0000, alt_sel_five_q}  :
    hit_sel_six_w   ? {24'h00_0000, alt_sel_six_q}   :
    hit_sel_seven_w ? {24'h00_0000, alt_sel_seven_q} :
    hit_view_w      ? {port_seven_latch_q, port_six_latch_q,
                       port_five_latch_q, port_three_latch_q} :
                      32'h0000_0000;

  // port three alone also takes single-bit set and clear
  assign port_three_latch_d =
    (lane_w & hit_three_w) ? wbyte_w :
    (lane_w & hit_set_w)   ? (port_three_latch_q | wbyte_w) :
    (lane_w & hit_clr_w)   ? (port_three_latch_q & ~wbyte_w) :
                             port_three_latch_q;

  // the other ports are written only as a whole byte
  assign port_five_latch_d  = (lane_w & hit_five_w) ?
                              wbyte_w : port_five_latch_q;
  assign port_six_latch_d   = (lane_w & hit_six_w) ?
                              wbyte_w : port_six_latch_q;
  assign port_seven_latch_d = (lane_w & hit_seven_w) ?
                              wbyte_w : port_seven_latch_q;

  // bus handshake and read data
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      if (pready_d) begin
        prdata_q  <= pwrite_i ? 32'h0000_0000 : rd_data_w;
        pslverr_q <= ~mapped_w; // unmapped address answers with error
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // port latches
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      port_three_latch_q <= LATCH_RESET;
      port_five_latch_q  <= LATCH_RESET;
      port_six_latch_q   <= LATCH_RESET;
      port_seven_latch_q <= LATCH_RESET;
    end else begin
      port_three_latch_q <= port_three_latch_d;
      port_five_latch_q  <= port_five_latch_d;
      port_six_latch_q   <= port_six_latch_d;
      port_seven_latch_q <= port_seven_latch_d;
    end
  end

  // alternate selects; reset leaves every pin as plain gpio
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      alt_sel_three_q <= ALT_SEL_RESET;
      alt_sel_five_q  <= ALT_SEL_RESET;
      alt_sel_six_q   <= ALT_SEL_RESET;
      alt_sel_seven_q <= ALT_SEL_RESET;
    end else if (lane_w) begin
      if (hit_sel_three_w) begin
        alt_sel_three_q <= wbyte_w;
      end
      if (hit_sel_five_w) begin
        alt_sel_five_q <= wbyte_w;
      end
      if (hit_sel_six_w) begin
        alt_sel_six_q <= wbyte_w;
      end
      if (hit_sel_seven_w) begin
        alt_sel_seven_q <= wbyte_w;
      end
    end
  end

  // peripheral outputs placed on their pins
  assign three_alt_w = {alt_out_i.rd_strobe,
                        alt_out_i.wr_strobe,
                        4'h0,
                        alt_out_i.txd,
                        1'b0};
  assign five_alt_w  = {alt_out_i.lcd_segment_out[15:10],
                        alt_out_i.pulse_channel_seven,
                        alt_out_i.pulse_channel_six};
  assign six_alt_w   = alt_out_i.lcd_segment_out[23:16];
  assign seven_alt_w = alt_out_i.lcd_segment_out[31:24];

  // one mux per port; only output-type alternates ever drive
  port_pin_mux u_mux_three (
    .latch_i     (port_three_latch_q),
    .alt_sel_i   (alt_sel_three_q),
    .alt_val_i   (three_alt_w),
    .alt_drive_i (THREE_ALT_DRIVE),
    .pin_o       (three_pin_d),
    .pin_oe_o    (three_oe_d)
  );

  port_pin_mux u_mux_five (
    .latch_i     (port_five_latch_q),
    .alt_sel_i   (alt_sel_five_q),
    .alt_val_i   (five_alt_w),
    .alt_drive_i (FULL_ALT_DRIVE),
    .pin_o       (five_pin_d),
    .pin_oe_o    (five_oe_d)
  );

  port_pin_mux u_mux_six (
    .latch_i     (port_six_latch_q),
    .alt_sel_i   (alt_sel_six_q),
    .alt_val_i   (six_alt_w),
    .alt_drive_i (FULL_ALT_DRIVE),
    .pin_o       (six_pin_d),
    .pin_oe_o    (six_oe_d)
  );

  port_pin_mux u_mux_seven (
    .latch_i     (port_seven_latch_q),
    .alt_sel_i   (alt_sel_seven_q),
    .alt_val_i   (seven_alt_w),
    .alt_drive_i (FULL_ALT_DRIVE),
    .pin_o       (seven_pin_d),
    .pin_oe_o    (seven_oe_d)
  );

  // alternate inputs see the pin only while its latch holds one;
  // a zero latch drives the pin low, so the input reads low too
  assign alt_in_d.timer_one_count_in  = three_sync_w[CNT_ONE_BIT] &
                                        port_three_latch_q[CNT_ONE_BIT];
  assign alt_in_d.capture_one_in      = alt_in_d.timer_one_count_in;
  assign alt_in_d.quadrature_in_b     = alt_in_d.timer_one_count_in;
  assign alt_in_d.timer_zero_count_in = three_sync_w[CNT_ZERO_BIT] &
                                        port_three_latch_q[CNT_ZERO_BIT];
  assign alt_in_d.capture_zero_in     = alt_in_d.timer_zero_count_in;
  assign alt_in_d.quadrature_in_a     = alt_in_d.timer_zero_count_in;
  assign alt_in_d.ext_irq_one         = three_sync_w[IRQ_ONE_BIT] &
                                        port_three_latch_q[IRQ_ONE_BIT];
  assign alt_in_d.ext_irq_zero        = three_sync_w[IRQ_ZERO_BIT] &
                                        port_three_latch_q[IRQ_ZERO_BIT];
  assign alt_in_d.rxd                 = three_sync_w[RXD_BIT] &
                                        port_three_latch_q[RXD_BIT];

  // peripheral inputs registered; costs one cycle of latency
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      alt_in_q <= '0;
    end else begin
      alt_in_q <= alt_in_d;
    end
  end

  // pin drive registered so pins never glitch on bus decode
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      three_pin_q <= 8'h00;
      three_oe_q  <= 8'h00;
      five_pin_q  <= 8'h00;
      five_oe_q   <= 8'h00;
      six_pin_q   <= 8'h00;
      six_oe_q    <= 8'h00;
      seven_pin_q <= 8'h00;
      seven_oe_q  <= 8'h00;
    end else begin
      three_pin_q <= three_pin_d;
      three_oe_q  <= three_oe_d;
      five_pin_q  <= five_pin_d;
      five_oe_q   <= five_oe_d;
      six_pin_q   <= six_pin_d;
      six_oe_q    <= six_oe_d;
      seven_pin_q <= seven_pin_d;
      seven_oe_q  <= seven_oe_d;
    end
  end

  // outputs
  assign prdata_o            = prdata_q;
  assign pready_o            = pready_q;
  assign pslverr_o           = pslverr_q;
  assign port_three_pin_o    = three_pin_q;
  assign port_three_pin_oe_o = three_oe_q;
  assign port_five_pin_o     = five_pin_q;
  assign port_five_pin_oe_o  = five_oe_q;
  assign port_six_pin_o      = six_pin_q;
  assign port_six_pin_oe_o   = six_oe_q;
  assign port_seven_pin_o    = seven_pin_q;
  assign port_seven_pin_oe_o = seven_oe_q;
  assign alt_in_o            = alt_in_q;

endmodule : multi_port_gpio_alt_functions

/* File: verif/gpio_alt_assertions.sv */
`timescale 1ns/1ps
module gpio_alt_assertions
  import gpio_alt_pkg::*;
(
  // clock, reset and apb
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // pins and peripherals
  input wire logic [7:0]  port_three_pin_i,
  input wire logic [7:0]  port_three_pin_o,
  input wire logic [7:0]  port_three_pin_oe_o,
  input wire logic [7:0]  port_five_pin_o,
  input wire logic [7:0]  port_five_pin_oe_o,
  input wire logic [7:0]  port_six_pin_o,
  input wire logic [7:0]  port_six_pin_oe_o,
  input wire logic [7:0]  port_seven_pin_o,
  input wire logic [7:0]  port_seven_pin_oe_o,
  input wire alt_out_type alt_out_i,
  input wire alt_in_type  alt_in_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  // cycles since reset: synchronisers hold reset ones for a few edges
  logic [2:0] up_q;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  // pins actively driven high, per port
  wire logic       settled = up_q > 3'h4;
  wire logic [7:0] hi3     = port_three_pin_oe_o & port_three_pin_o;
  wire logic [7:0] hi5     = port_five_pin_oe_o & port_five_pin_o;
  wire logic [7:0] hi6     = port_six_pin_oe_o & port_six_pin_o;
  wire logic [7:0] hi7     = port_seven_pin_oe_o & port_seven_pin_o;

  a_ready_delay: assert property (psel_i && !penable_i |=>
    !pready_o ##1 pready_o) else $error("pready not in access cycle two");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_err_pair: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_write_rdata: assert property (pready_o && pwrite_i |->
    prdata_o == 32'h0000_0000) else $error("read data on a write");
  a_three_inputs: assert property ((hi3 & 8'h3d) == 8'h00)
    else $error("input pin of port three driven high");
  a_three_alt: assert property ((hi3 & ~$past({
    alt_out_i.rd_strobe, alt_out_i.wr_strobe, 4'h0, alt_out_i.txd, 1'b0}))
    == 8'h00) else $error("port three high without its strobe or txd");
  a_five_alt: assert property ((hi5 & ~$past({
    alt_out_i.lcd_segment_out[15:10], alt_out_i.pulse_channel_seven,
    alt_out_i.pulse_channel_six})) == 8'h00)
    else $error("port five high without its source");
  a_six_seg: assert property (
    (hi6 & ~$past(alt_out_i.lcd_segment_out[23:16])) == 8'h00)
    else $error("port six high without its segment");
  a_seven_seg: assert property (
    (hi7 & ~$past(alt_out_i.lcd_segment_out[31:24])) == 8'h00)
    else $error("port seven high without its segment");
  a_irq_sync: assert property (settled
    && !$past(port_three_pin_i[2], 3) |-> !alt_in_o.ext_irq_zero)
    else $error("irq zero high on low pin");
  a_count_sync: assert property (settled
    && !$past(port_three_pin_i[5], 3) |-> !(alt_in_o.timer_one_count_in
    || alt_in_o.capture_one_in || alt_in_o.quadrature_in_b))
    else $error("timer one input high on low pin");
endmodule : gpio_alt_assertions

bind multi_port_gpio_alt_functions gpio_alt_assertions gpio_alt_assertions_i (
  .clk_sys_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .prdata_o, .pready_o,
  .pslverr_o, .port_three_pin_i, .port_three_pin_o, .port_three_pin_oe_o,
  .port_five_pin_o, .port_five_pin_oe_o, .port_six_pin_o,
  .port_six_pin_oe_o, .port_seven_pin_o, .port_seven_pin_oe_o, .alt_out_i,
  .alt_in_o);

/* File: verif/pin_partner.sv */
`timescale 1ns/1ps
module pin_partner (
  // block drive
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] oe_i,
  // outside load pulling released pins low
  input  wire logic [7:0] pull_low_i,
  // resolved wire level
  output logic      [7:0] wire_o
);
  // released pins sit on the pull-up unless the load pulls them down
  assign wire_o = (oe_i & pin_o_i) | (~oe_i & ~pull_low_i);
endmodule : pin_partner

/* File: verif/multi_port_gpio_alt_functions_test.sv */
`timescale 1ns/1ps
module multi_port_gpio_alt_functions_test;
  import gpio_alt_pkg::*;
  // stimulus and observed signals
  logic        clk_sys_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic [11:0] paddr     = 12'h000;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic [3:0]  pstrb     = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pl [4]    = '{default: 8'h00};
  wire  [7:0]  po [4];
  wire  [7:0]  oe [4];
  wire  [7:0]  pw [4];
  alt_out_type alt_out   = '0;
  alt_in_type  alt_in;
  // reference model state
  logic [7:0]  lat [4]   = '{default: 8'hff};
  logic [7:0]  sel [4]   = '{default: 8'h00};
  logic [31:0] seed      = 32'h0000_004b;
  int          n_errors  = 0;
  int          cmp_count = 0;
  int          cyc       = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  multi_port_gpio_alt_functions multi_port_gpio_alt_functions_i (
    .clk_sys_i, .srst_i, .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .port_three_pin_i(pw[0]),
    .port_three_pin_o(po[0]), .port_three_pin_oe_o(oe[0]),
    .port_five_pin_i(pw[1]), .port_five_pin_o(po[1]),
    .port_five_pin_oe_o(oe[1]), .port_six_pin_i(pw[2]),
    .port_six_pin_o(po[2]), .port_six_pin_oe_o(oe[2]),
    .port_seven_pin_i(pw[3]), .port_seven_pin_o(po[3]),
    .port_seven_pin_oe_o(oe[3]), .alt_out_i(alt_out), .alt_in_o(alt_in));

  // one pin load model per port
  for (genvar p = 0; p < 4; p++) begin : g
    pin_partner pin_partner_i (.pin_o_i(po[p]), .oe_i(oe[p]),
      .pull_low_i(pl[p]), .wire_o(pw[p]));
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // alternate output value and drive-capable mask of a port
  function automatic logic [15:0] alt_of(int p);
    case (p)
      0: return {THREE_ALT_DRIVE, alt_out.rd_strobe, alt_out.wr_strobe,
                 4'h0, alt_out.txd, 1'b0};
      1: return {FULL_ALT_DRIVE, alt_out.lcd_segment_out[15:10],
                 alt_out.pulse_channel_seven,
                 alt_out.pulse_channel_six};
      2: return {FULL_ALT_DRIVE, alt_out.lcd_segment_out[23:16]};
      default: return {FULL_ALT_DRIVE, alt_out.lcd_segment_out[31:24]};
    endcase
  endfunction : alt_of

  // latch zero pulls low, else selected alternate, else pull-up or load
  function automatic logic [7:0] exp_wire(int p);
    logic [15:0] a;
    a = alt_of(p);
    return lat[p] & ((sel[p] & a[15:8] & a[7:0])
           | (~(sel[p] & a[15:8]) & ~pl[p]));
  endfunction : exp_wire

  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : report

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask : chk_rd

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask : chk_pin

  // one apb transfer, request held until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic close_out();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // bound on the whole run
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    logic [31:0] q;
    logic [31:0] r;
    logic [7:0]  e;
    logic        err;
    repeat (5) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    apb(1'b0, LATCH_VIEW_ADDR, 32'h0, q, err);
    chk_rd(q, 32'hffff_ffff);
    for (int p = 0; p < 4; p++) begin
      apb(1'b0, ALT_SEL_THREE_ADDR + 12'(4 * p), 32'h0, q, err);
      chk_rd(q, 32'h0000_0000);
    end
    // unmapped address is refused; a write without its strobe is ignored
    apb(1'b1, 12'h0fc, 32'h0000_0000, q, err);
    chk_rd({31'h0, err}, 32'h0000_0001);
    pstrb <= 4'h0;
    apb(1'b1, {2'b00, PORT_FIVE_IDX, 2'b00}, 32'h0000_0000, q, err);
    pstrb <= 4'hf;
    apb(1'b0, LATCH_VIEW_ADDR, 32'h0, q, err);
    chk_rd(q, 32'hffff_ffff);
    for (int it = 0; it < 40; it++) begin
      for (int p = 0; p < 4; p++) begin
        lat[p] = 8'(rnd());
        sel[p] = 8'(rnd());
        apb(1'b1, {2'b00, PORT_THREE_IDX + 8'(p), 2'b00}, {24'h0, lat[p]},
            q, err);
        apb(1'b1, ALT_SEL_THREE_ADDR + 12'(4 * p), {24'h0, sel[p]}, q, err);
      end
      // single-bit set and clear exist for port three only
      e = 8'(rnd());
      apb(1'b1, THREE_BIT_SET_ADDR, {24'h0, e}, q, err);
      lat[0] = lat[0] | e;
      e = 8'(rnd());
      apb(1'b1, THREE_BIT_CLR_ADDR, {24'h0, e}, q, err);
      lat[0] = lat[0] & ~e;
      r = rnd();
      alt_out <= r[$bits(alt_out_type)-1:0];
      for (int p = 0; p < 4; p++) pl[p] <= 8'(rnd());
      repeat (5) @(posedge clk_sys_i);
      for (int p = 0; p < 4; p++) begin
        r = 32'(alt_of(p));
        chk_pin({24'h0, pw[p]},
                {24'h0, exp_wire(p)});
        chk_pin({24'h0, oe[p]},
                {24'h0, ~lat[p] | (sel[p] & r[15:8])});
      end
      e = exp_wire(0) & lat[0];
      chk_pin({23'h0, alt_in},
              {23'h0, e[5], e[5], e[5], e[4], e[4], e[4], e[3], e[2], e[0]});
      for (int p = 0; p < 4; p++) begin
        apb(1'b0, {2'b00, PORT_THREE_IDX + 8'(p), 2'b00}, 32'h0, q, err);
        chk_rd(q, {24'h0, exp_wire(p)});
      end
      apb(1'b0, LATCH_VIEW_ADDR, 32'h0, q, err);
      chk_rd(q,
             {lat[3], lat[2], lat[1], lat[0]});
    end
    close_out();
  end
endmodule : multi_port_gpio_alt_functions_test
